// ==== src/frac_n_ctrl.sv ====
// fractional-n divider word, modulator and charge pump control
// Function
// - output is fpfd times intg plus frac/2^24
// - integer ratio kept within 36 to 65567
// - frac is 24-bit step in fpfd/2^24
// - pfd rate is reference divided by R
// - slip guard holds gain maximal until settled
// - slip guard sensitivity follows magnitude field
// - 3-bit gain codes switch 500/1000/500uA sources
// - 4-bit trims add 7uA per step
// - 3-bit leak codes add 55uA per step
// - integer mode stops modulator, fixed ratio
`include "fracn_map.svh"

module frac_n_ctrl
    import fracn_pkg::*;
(
    input wire logic clk, // system clock, 50 MHz
    input wire logic arst_n, // async reset, active low
    input wire logic [7:0] addr, // register byte address
    input wire logic [31:0] wdata, // register write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd
    input wire logic ref_in, // reference oscillator pin
    input wire logic pfd_up, // detector up pulse pin
    input wire logic pfd_dn, // detector down pulse pin
    output logic pfd_tick, // one pulse per pfd cycle
    output ratio_t div_ratio, // divide ratio to prescaler
    output code3_t pump_up_gain_code, // up source enables
    output code3_t pump_down_gain_code, // down source enables
    output code4_t pump_up_fine_adjust, // up trim
    output code4_t pump_down_fine_adjust, // down trim
    output code3_t pump_up_leak_code, // up leakage
    output code3_t pump_down_leak_code, // down leakage
    output ua_t pump_up_ua, // up current in uA
    output ua_t pump_down_ua, // down current in uA
    output logic [8:0] leak_up_ua, // up leakage in uA
    output logic [8:0] leak_down_ua // down leakage in uA
);
    ratio_t intg_ff;
    frac_t frac_ff;
    rdiv_t rdiv_ff;
    logic [6:0] mode_ff;
    logic [19:0] pump_ff;
    rdiv_t rcnt_ff;
    logic boost_ff;
    logic last_dir_ff;
    logic [3:0] run_cnt_ff;
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic [2:0] s3_ff;
    logic [2:0] stable_ff;
    logic [2:0] rise;
    logic frac_mode;
    logic [3:0] slip_limit;
    code3_t up_gain;
    code3_t dn_gain;
    dsm_if dsm ();

    // pin synchronisers: ref, up, down
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_sync
            logic pin;
            if (i == 0) begin : g_ref
                assign pin = ref_in;
            end else if (i == 1) begin : g_up
                assign pin = pfd_up;
            end else begin : g_dn
                assign pin = pfd_dn;
            end
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_ff[i] <= 1'b0;
                    s2_ff[i] <= 1'b0;
                    s3_ff[i] <= 1'b0;
                    stable_ff[i] <= 1'b0;
                end else begin
                    s1_ff[i] <= pin;
                    s2_ff[i] <= s1_ff[i];
                    s3_ff[i] <= s2_ff[i];
                    if (s2_ff[i] == s3_ff[i]) begin
                        stable_ff[i] <= s3_ff[i];
                    end
                end
            end
            assign rise[i] = s2_ff[i] & s3_ff[i] & ~stable_ff[i];
        end
    endgenerate

    assign frac_mode = mode_ff[`MODE_RUN_BIT] & mode_ff[`MODE_BUF_BIT];
    assign slip_limit = {1'b0, mode_ff[`MODE_MAG_MSB:`MODE_MAG_LSB]} + 4'h1;

    // register writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            intg_ff <= `INTG_RST;
            frac_ff <= `FRAC_RST;
            rdiv_ff <= `RDIV_RST;
            mode_ff <= `MODE_RST;
            pump_ff <= `PUMP_RST;
        end else if (wr) begin
            case (addr)
                `ADDR_INTG: begin
                    // out-of-range ratios are ignored
                    if (wdata[16:0] >= `INTG_MIN && wdata[16:0] <= `INTG_MAX && wdata[31:17] == 15'h0000) begin
                        intg_ff <= wdata[16:0];
                    end
                end
                `ADDR_FRAC: frac_ff <= wdata[23:0];
                `ADDR_RDIV: rdiv_ff <= wdata[13:0];
                `ADDR_MODE: mode_ff <= wdata[6:0];
                `ADDR_PUMP: pump_ff <= wdata[19:0];
                default: ;
            endcase
        end
    end

    // register reads
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                `ADDR_INTG: rdata <= {15'h0000, intg_ff};
                `ADDR_FRAC: rdata <= {8'h00, frac_ff};
                `ADDR_RDIV: rdata <= {18'h00000, rdiv_ff};
                `ADDR_MODE: rdata <= {25'h0000000, mode_ff};
                `ADDR_PUMP: rdata <= {12'h000, pump_ff};
                `ADDR_STAT: rdata <= {13'h0000, frac_mode, boost_ff, div_ratio};
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    // reference path divider: one pfd tick every R reference edges
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rcnt_ff <= 14'h0000;
            pfd_tick <= 1'b0;
        end else begin
            pfd_tick <= 1'b0;
            if (rise[0]) begin
                if (rcnt_ff + 14'h0001 >= rdiv_ff) begin
                    rcnt_ff <= 14'h0000;
                    pfd_tick <= 1'b1;
                end else begin
                    rcnt_ff <= rcnt_ff + 14'h0001;
                end
            end
        end
    end

    assign dsm.tick = pfd_tick;
    assign dsm.run = frac_mode;
    assign dsm.intg = intg_ff;
    assign dsm.frac = frac_ff;

    dsm_accum u_dsm (
        .clk(clk),
        .arst_n(arst_n),
        .dsm(dsm)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_ratio <= `INTG_RST;
        end else begin
            div_ratio <= dsm.ratio;
        end
    end

    // slip guard: a run of same-direction pulses means frequency error
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            boost_ff <= 1'b0;
            last_dir_ff <= 1'b0;
            run_cnt_ff <= 4'h0;
        end else if (!mode_ff[`MODE_CSP_BIT]) begin
            boost_ff <= 1'b0;
            run_cnt_ff <= 4'h0;
        end else if (rise[1] ^ rise[2]) begin
            last_dir_ff <= rise[2];
            if (rise[2] == last_dir_ff) begin
                if (run_cnt_ff != 4'hF) begin
                    run_cnt_ff <= run_cnt_ff + 4'h1;
                end
                if (run_cnt_ff + 4'h1 >= slip_limit) begin
                    boost_ff <= 1'b1;
                end
            end else begin
                // opposite pulse: error near zero, a new run of one
                run_cnt_ff <= 4'h1;
                boost_ff <= (slip_limit == 4'h1);
            end
        end
    end

    assign up_gain = boost_ff ? `GAIN_MAX : pump_ff[`PUMP_UPG_LSB +: 3];
    assign dn_gain = boost_ff ? `GAIN_MAX : pump_ff[`PUMP_DNG_LSB +: 3];

    function automatic ua_t pump_ua(input code3_t g, input code4_t t);
        // code bit 1 selects the 1 mA source, in 010, 011, 110 and 111
        pump_ua = (g[0] ? `SRC_SMALL_UA : 12'h000) + (g[1] ? `SRC_LARGE_UA : 12'h000)
            + (g[2] ? `SRC_SMALL_UA : 12'h000) + ua_t'(`TRIM_STEP_UA * {8'h00, t});
    endfunction

    // pump settings to the analog side
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pump_up_gain_code <= 3'h2;
            pump_down_gain_code <= 3'h2;
            pump_up_fine_adjust <= 4'h0;
            pump_down_fine_adjust <= 4'h0;
            pump_up_leak_code <= 3'h0;
            pump_down_leak_code <= 3'h0;
            pump_up_ua <= `SRC_LARGE_UA;
            pump_down_ua <= `SRC_LARGE_UA;
            leak_up_ua <= 9'h000;
            leak_down_ua <= 9'h000;
        end else begin
            pump_up_gain_code <= up_gain;
            pump_down_gain_code <= dn_gain;
            pump_up_fine_adjust <= pump_ff[`PUMP_UPT_LSB +: 4];
            pump_down_fine_adjust <= pump_ff[`PUMP_DNT_LSB +: 4];
            pump_up_leak_code <= pump_ff[`PUMP_UPL_LSB +: 3];
            pump_down_leak_code <= pump_ff[`PUMP_DNL_LSB +: 3];
            pump_up_ua <= pump_ua(up_gain, pump_ff[`PUMP_UPT_LSB +: 4]);
            pump_down_ua <= pump_ua(dn_gain, pump_ff[`PUMP_DNT_LSB +: 4]);
            leak_up_ua <= 9'(`LEAK_STEP_UA * {6'h00, pump_ff[`PUMP_UPL_LSB +: 3]});
            leak_down_ua <= 9'(`LEAK_STEP_UA * {6'h00, pump_ff[`PUMP_DNL_LSB +: 3]});
        end
    end
endmodule

// ==== src/fracn_map.svh ====
// register offsets, field positions, reset values and analog weights of the loop controller
`ifndef FRACN_MAP_SVH
`define FRACN_MAP_SVH

`define ADDR_INTG 8'h00
`define ADDR_FRAC 8'h04
`define ADDR_RDIV 8'h08
`define ADDR_MODE 8'h0C
`define ADDR_PUMP 8'h10
`define ADDR_STAT 8'h14

`define INTG_MIN 17'h00024
`define INTG_MAX 17'h1001F
`define INTG_RST 17'h00064
`define FRAC_RST 24'h000000
`define RDIV_RST 14'h0001
`define MODE_RST 7'h00
`define PUMP_RST 20'h00012

`define MODE_RUN_BIT 0
`define MODE_BUF_BIT 1
`define MODE_CSP_BIT 2
`define MODE_MAG_LSB 4
`define MODE_MAG_MSB 6

`define PUMP_UPG_LSB 0
`define PUMP_DNG_LSB 3
`define PUMP_UPT_LSB 6
`define PUMP_DNT_LSB 10
`define PUMP_UPL_LSB 14
`define PUMP_DNL_LSB 17

`define STAT_BOOST_BIT 17
`define STAT_FRAC_BIT 18

`define SRC_SMALL_UA 12'h1F4
`define SRC_LARGE_UA 12'h3E8
`define TRIM_STEP_UA 12'h007
`define LEAK_STEP_UA 9'h037
`define GAIN_MAX 3'h7

`endif

// ==== src/fracn_pkg.sv ====
// shared types of the fractional-n loop controller
package fracn_pkg;
    typedef logic [16:0] ratio_t;
    typedef logic [23:0] frac_t;
    typedef logic [13:0] rdiv_t;
    typedef logic [2:0] code3_t;
    typedef logic [3:0] code4_t;
    typedef logic [11:0] ua_t;
endpackage

// ==== src/dsm_if.sv ====
// link between the loop controller and its delta-sigma accumulator
interface dsm_if;
    import fracn_pkg::*;
    logic tick;
    logic run;
    ratio_t intg;
    frac_t frac;
    ratio_t ratio;
    logic carry;
    modport ctrl (output tick, output run, output intg, output frac, input ratio, input carry);
    modport accum (input tick, input run, input intg, input frac, output ratio, output carry);
endinterface

// ==== src/dsm_accum.sv ====
// first-order delta-sigma accumulator producing the per-cycle divide ratio
module dsm_accum
    import fracn_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic arst_n, // async reset, active low
    dsm_if.accum dsm // modulator link
);
    frac_t acc_ff;
    logic [24:0] sum;

    assign sum = {1'b0, acc_ff} + {1'b0, dsm.frac};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_ff <= `FRAC_RST;
            dsm.ratio <= `INTG_RST;
            dsm.carry <= 1'b0;
        end else if (dsm.tick) begin
            if (dsm.run) begin
                // overflow adds one to the ratio; average becomes intg + frac / 2^24
                acc_ff <= sum[23:0];
                dsm.ratio <= ratio_t'(dsm.intg + {16'h0000, sum[24]});
                dsm.carry <= sum[24];
            end else begin
                acc_ff <= `FRAC_RST;
                dsm.ratio <= dsm.intg;
                dsm.carry <= 1'b0;
            end
        end
    end
endmodule

// ==== verif/frac_n_ctrl_sva.sv ====
// port checks for the fractional-n loop controller
module frac_n_ctrl_sva
    import fracn_pkg::*;
(
    input wire logic clk, // clock
    input wire logic arst_n, // reset
    input wire logic [7:0] addr, // address
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [31:0] rdata, // read data
    input wire logic pfd_tick, // pfd tick
    input wire ratio_t div_ratio, // ratio
    input wire code3_t pump_up_gain_code, // up gain
    input wire code3_t pump_down_gain_code, // down gain
    input wire code4_t pump_up_fine_adjust, // up trim
    input wire ua_t pump_up_ua, // up current
    input wire code3_t pump_down_leak_code, // down leak
    input wire logic [8:0] leak_down_ua // down leak current
);
    ua_t src_ua;
    // '010' is the 1 mA source
    assign src_ua = (pump_up_gain_code[0] ? 12'h1F4 : 12'h000) + (pump_up_gain_code[1] ? 12'h3E8 : 12'h000)
        + (pump_up_gain_code[2] ? 12'h1F4 : 12'h000) + 12'h007 * pump_up_fine_adjust;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    tick_pulse_a: assert property (pfd_tick |=> !pfd_tick)
        else $error("tick longer than one cycle");
    ratio_range_a: assert property (div_ratio >= 17'h00024 && div_ratio <= 17'h10020)
        else $error("ratio out of range");
    ratio_tick_a: assert property ($changed(div_ratio) |-> $past(pfd_tick, 2))
        else $error("ratio moved without tick");
    pump_ua_a: assert property (pump_up_gain_code != 3'h7 |-> pump_up_ua == src_ua)
        else $error("up current wrong");
    leak_ua_a: assert property (leak_down_ua == 9'h037 * pump_down_leak_code)
        else $error("down leak wrong");
    trim_write_a: assert property (wr && addr == 8'h10 |-> ##2 pump_up_fine_adjust == $past(wdata[9:6], 2))
        else $error("trim not written");
    boost_gain_a: assert property (rd && addr == 8'h14 ##1 rdata[17] |-> pump_up_gain_code == 3'h7 &&
        pump_down_gain_code == 3'h7) else $error("boost without max gain");
    stat_ratio_a: assert property (rd && addr == 8'h14 |=> rdata[16:0] == $past(div_ratio))
        else $error("status ratio wrong");
endmodule
bind frac_n_ctrl frac_n_ctrl_sva frac_n_ctrl_sva_inst (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
    .pfd_tick, .div_ratio, .pump_up_gain_code, .pump_down_gain_code, .pump_up_fine_adjust, .pump_up_ua,
    .pump_down_leak_code, .leak_down_ua);

// ==== verif/loop_model.sv ====
// reference source and detector pulses on the loop side
module loop_model (
    input wire logic clk, // clock
    input wire logic ref_run, // reference enable
    output logic ref_in, // reference pin
    output logic pfd_up, // up pulse pin
    output logic pfd_dn // down pulse pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph_ff = 3'h0;
    initial {ref_in, pfd_up, pfd_dn} = 3'h0;
    // period of 8 clocks, held when stopped
    always @(posedge clk) if (ref_run) {ref_in, ph_ff} <= {ph_ff[2], ph_ff + 3'h1};
    task automatic pulse(input logic up);
        if (up)
            pfd_up <= 1'b1;
        else
            pfd_dn <= 1'b1;
        repeat (3) @(posedge clk);
        {pfd_up, pfd_dn} <= 2'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask
endmodule

// ==== verif/frac_n_ctrl_tb.sv ====
// self-checking bench for the loop controller
`include "fracn_map.svh"
module frac_n_ctrl_tb
    import fracn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, wr, rd, ref_run, ref_in, pfd_up, pfd_dn, pfd_tick;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, r;
    ratio_t div_ratio;
    code3_t ugc, dgc, ulc, dlc;
    code4_t uft, dft;
    ua_t uua, dua;
    logic [8:0] lua, lda;
    int fail_count = 0, n_checks = 0, n;
    logic [31:0] s;
    // pump word, up uA, down uA, up leak, down leak
    logic [31:0] rows [3][5] = '{'{32'h1C3D1, 32'h25D, 32'h3E8, 32'h181, 32'h0},
        '{32'hA207C, 32'h1FB, 32'h808, 32'h0, 32'h113}, '{32'hE7C02, 32'h3E8, 32'h69, 32'h37, 32'h181}};
    frac_n_ctrl frac_n_ctrl_inst (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .ref_in, .pfd_up, .pfd_dn,
        .pfd_tick, .div_ratio, .pump_up_gain_code(ugc), .pump_down_gain_code(dgc), .pump_up_fine_adjust(uft),
        .pump_down_fine_adjust(dft), .pump_up_leak_code(ulc), .pump_down_leak_code(dlc), .pump_up_ua(uua),
        .pump_down_ua(dua), .leak_up_ua(lua), .leak_down_ua(lda));
    loop_model loop_model_inst (.clk, .ref_run, .ref_in, .pfd_up, .pfd_dn);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 r = rdata;
        @(posedge clk);
    endtask
    // n ends as the cycles waited
    task automatic wtick;
        for (n = 1; n <= 200; n++) begin
            @(posedge clk);
            #1;
            if (pfd_tick === 1'b1)
                return;
        end
        fail_count++;
        end_of_test();
    endtask
    initial begin
        {arst_n, wr, rd, addr, wdata, ref_run} = '0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        cyc(1);
        chk(div_ratio, 32'h64);
        chk(uua, 32'h3E8);
        chk(lda, 32'h0);
        foreach (rows[i]) begin
            wreg(`ADDR_PUMP, rows[i][0]);
            #1;
            chk(ugc, rows[i][0][2:0]);
            chk(dgc, rows[i][0][5:3]);
            chk(uft, rows[i][0][9:6]);
            chk(dft, rows[i][0][13:10]);
            chk(ulc, rows[i][0][16:14]);
            chk(dlc, rows[i][0][19:17]);
            chk(uua, rows[i][1]);
            chk(dua, rows[i][2]);
            chk(lua, rows[i][3]);
            chk(lda, rows[i][4]);
        end
        wreg(`ADDR_INTG, 32'h23);
        rreg(`ADDR_INTG);
        chk(r, 32'h64);
        wreg(`ADDR_INTG, 32'h1001F);
        wreg(`ADDR_INTG, 32'h10020);
        rreg(`ADDR_INTG);
        chk(r, 32'h1001F);
        rreg(8'h18);
        chk(r, 32'h0);
        wreg(`ADDR_INTG, 32'h24);
        wreg(`ADDR_FRAC, 32'h800000);
        wreg(`ADDR_RDIV, 32'h3);
        ref_run <= 1'b1;
        repeat (3) wtick();
        chk(n, 32'h18);
        wreg(`ADDR_RDIV, 32'h1);
        for (int k = 0; k < 2; k++) begin
            wreg(`ADDR_PUMP, k ? 32'h12 : 32'hE7C02);
            wreg(`ADDR_MODE, k ? 32'h1 : 32'h3);
            repeat (3) wtick();
            s = 0;
            repeat (16) begin
                wtick();
                s += div_ratio;
            end
            chk(s, k ? 32'h240 : 32'h248);
            rreg(`ADDR_STAT);
            chk(r[18], k ? 32'h0 : 32'h1);
        end
        wreg(`ADDR_MODE, 32'h24);
        repeat (2) loop_model_inst.pulse(1'b1);
        chk(ugc, 32'h2);
        loop_model_inst.pulse(1'b1);
        cyc(2);
        chk(ugc, 32'h7);
        chk(dgc, 32'h7);
        rreg(`ADDR_STAT);
        chk(r[17], 32'h1);
        loop_model_inst.pulse(1'b0);
        cyc(2);
        chk(ugc, 32'h2);
        wreg(`ADDR_MODE, 32'h4);
        loop_model_inst.pulse(1'b1);
        cyc(2);
        chk(ugc, 32'h7);
        wreg(`ADDR_MODE, 32'h0);
        cyc(2);
        chk(ugc, 32'h2);
        // reset in mid-run brings ratio and registers back
        @(posedge clk);
        arst_n <= 1'b0;
        cyc(2);
        chk(div_ratio, 32'h64);
        @(posedge clk);
        arst_n <= 1'b1;
        cyc(2);
        chk(div_ratio, 32'h64);
        chk(dgc, 32'h2);
        rreg(`ADDR_INTG);
        chk(r, 32'h64);
        end_of_test();
    end
endmodule
